// >>> fcd_host.sv
// Host-side sequencer that issues command cycles to a word-wide NOR flash
`timescale 1ns/1ps
module fcd_host (
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic                       clk_en,
   input  wire logic                       req_valid,
   output logic                            req_ready,
   input  wire fcd_pkg::fcd_req_s          req,
   output logic                            wdata_req,
   input  wire logic [fcd_pkg::DATA_W-1:0] wdata,
   output logic                            rsp_valid,
   output logic [fcd_pkg::DATA_W-1:0]      rsp_data,
   output logic                            suspended,
   output logic                            bypass,
   output fcd_pkg::fcd_pins_s              pins,
   input  wire logic [fcd_pkg::DATA_W-1:0] dq_in
);
   import fcd_pkg::*;

   // ----------------------------------------------------------------
   // Cycle list builder
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {FCD_ST_IDLE, FCD_ST_SETUP, FCD_ST_PULSE, FCD_ST_HOLD} fcd_st_e;

   fcd_st_e            st_r;
   fcd_req_s           cur_r;
   logic [4:0]         idx_r;
   logic [4:0]         last_r;
   logic [CNT_W-1:0]   cnt_r;
   logic               is_rd;
   logic [ADDR_W-1:0]  c_addr;
   logic [DATA_W-1:0]  c_data;
   logic               c_from_user;
   logic [ADDR_W-1:0]  sect_base;
   logic [ADDR_W-1:0]  page_base;

   assign sect_base = {cur_r.addr[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}};
   assign page_base = {cur_r.addr[ADDR_W-1:PAGE_LSB], {PAGE_LSB{1'b0}}};

   // Unlock writes drive only the low bits; upper data byte left zero
   always_comb begin
      c_addr      = UNLOCK1_ADDR;
      c_data      = UNLOCK1_DATA;
      c_from_user = 1'b0;
      is_rd       = 1'b0;
      if (idx_r == 5'h01) begin
         c_addr = UNLOCK2_ADDR;
         c_data = UNLOCK2_DATA;
      end
      case (cur_r.op)
         FCD_OP_READ, FCD_OP_IDREAD: begin
            c_addr = cur_r.addr;
            is_rd  = 1'b1;
         end
         FCD_OP_RESET:   c_data = CMD_RESET;
         FCD_OP_SUSPEND: c_data = CMD_SUSPEND;
         FCD_OP_RESUME:  c_data = CMD_RESUME;
         FCD_OP_CFI: begin
            c_addr = CFI_ADDR;
            c_data = CMD_CFI;
         end
         FCD_OP_IDENT:  if (idx_r == 5'h02) c_data = CMD_IDENT;
         FCD_OP_ABORT:  if (idx_r == 5'h02) c_data = CMD_RESET;
         FCD_OP_BYP_ON: if (idx_r == 5'h02) c_data = CMD_BYPASS;
         FCD_OP_BYP_OFF: c_data = (idx_r == 5'h00) ? CMD_IDENT : CMD_BYP_EXIT;
         FCD_OP_PROG: begin
            if (bypass) begin
               c_data = CMD_PROG;
               if (idx_r == 5'h01) begin
                  c_addr = cur_r.addr;
                  c_data = cur_r.data;
               end
            end else if (idx_r == 5'h02) begin
               c_data = CMD_PROG;
            end else if (idx_r == 5'h03) begin
               c_addr = cur_r.addr;
               c_data = cur_r.data;
            end
         end
         FCD_OP_BUF: begin
            if (idx_r == 5'h02) begin
               c_addr = sect_base;
               c_data = CMD_BUF_LOAD;
            end else if (idx_r == 5'h03) begin
               c_addr = sect_base;
               c_data = {11'h000, cur_r.count};
            end else if (idx_r == last_r) begin
               c_addr = sect_base;
               c_data = CMD_BUF_GO;
            end else if (idx_r > 5'h03) begin
               c_addr = page_base | ADDR_W'(idx_r - 5'h04);
               c_from_user = 1'b1;
            end
         end
         FCD_OP_ERASE: begin
            if (idx_r == 5'h02) c_data = CMD_ERASE_SU;
            // Second unlock pair needs 2AA/55 at the fifth write too
            if (idx_r == 5'h04) begin
               c_addr = UNLOCK2_ADDR;
               c_data = UNLOCK2_DATA;
            end
            if (idx_r == 5'h05) begin
               c_addr = sect_base;
               c_data = CMD_SEC_ERS;
            end
         end
         default: ;
      endcase
   end

   // ----------------------------------------------------------------
   // Sequence length and request intake
   // ----------------------------------------------------------------
   logic [4:0] len_nxt;
   always_comb begin
      case (req.op)
         FCD_OP_IDENT, FCD_OP_ABORT, FCD_OP_BYP_ON: len_nxt = 5'd2;
         FCD_OP_PROG:    len_nxt = bypass ? 5'd1 : 5'd3;
         FCD_OP_BYP_OFF: len_nxt = 5'd1;
         FCD_OP_ERASE:   len_nxt = 5'd5;
         // Page limit keeps the sequence inside 21 cycles
         FCD_OP_BUF:     len_nxt = 5'd5 + ((req.count > 5'(BUF_WORDS - 1)) ?
                                           5'(BUF_WORDS - 1) : req.count);
         default:        len_nxt = 5'd0;
      endcase
   end

   assign req_ready = (st_r == FCD_ST_IDLE);
   assign wdata_req = (st_r == FCD_ST_SETUP) && c_from_user && (cnt_r == '0);

   // ----------------------------------------------------------------
   // Bus cycle timing
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_r   <= FCD_ST_IDLE;
         cur_r  <= '0;
         idx_r  <= '0;
         last_r <= '0;
         cnt_r  <= '0;
      end else if (clk_en) begin
         case (st_r)
            FCD_ST_IDLE: begin
               if (req_valid) begin
                  cur_r <= req;
                  if (req.count > 5'(BUF_WORDS - 1))
                     cur_r.count <= 5'(BUF_WORDS - 1);
                  idx_r  <= '0;
                  last_r <= len_nxt;
                  cnt_r  <= '0;
                  st_r   <= FCD_ST_SETUP;
               end
            end
            FCD_ST_SETUP: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == CNT_W'(SETUP_CYC - 1)) begin
                  cnt_r <= '0;
                  st_r  <= FCD_ST_PULSE;
               end
            end
            FCD_ST_PULSE: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == CNT_W'((is_rd ? ACC_CYC : PULSE_CYC) - 1)) begin
                  cnt_r <= '0;
                  st_r  <= FCD_ST_HOLD;
               end
            end
            FCD_ST_HOLD: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == CNT_W'(HOLD_CYC - 1)) begin
                  cnt_r <= '0;
                  if (idx_r == last_r) begin
                     st_r <= FCD_ST_IDLE;
                  end else begin
                     idx_r <= idx_r + 1'b1;
                     st_r  <= FCD_ST_SETUP;
                  end
               end
            end
            default: st_r <= FCD_ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pins: address set in setup, strobes low in pulse; data held to hold
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] wr_data;
   assign wr_data = c_from_user ? wdata : c_data;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pins <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      end else if (clk_en) begin
         // ce_n falls in setup, ahead of we_n in pulse, so the address is stable at the later one
         pins.ce_n <= !(st_r == FCD_ST_PULSE || (st_r == FCD_ST_SETUP && cnt_r != '0));
         pins.we_n <= !(st_r == FCD_ST_PULSE && !is_rd);
         pins.oe_n <= !(st_r == FCD_ST_PULSE && is_rd);
         if (st_r == FCD_ST_SETUP && cnt_r == '0) begin
            pins.addr   <= c_addr;
            pins.dq_out <= wr_data;
            pins.dq_oe  <= !is_rd;
         end
         // Data kept through hold; the first rising strobe latches it
         if (st_r == FCD_ST_IDLE)
            pins.dq_oe <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read capture and mode tracking
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_data  <= '0;
      end else if (clk_en) begin
         rsp_valid <= 1'b0;
         if (st_r == FCD_ST_PULSE && is_rd && cnt_r == CNT_W'(ACC_CYC - 1)) begin
            rsp_valid <= 1'b1;
            // Upper byte is don't care in identification reads
            rsp_data  <= (cur_r.op == FCD_OP_IDREAD) ? {8'h00, dq_in[7:0]} : dq_in;
         end
      end
   end

   logic seq_done;
   assign seq_done = clk_en && st_r == FCD_ST_HOLD && idx_r == last_r
                     && cnt_r == CNT_W'(HOLD_CYC - 1);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bypass    <= 1'b0;
         suspended <= 1'b0;
      end else if (seq_done) begin
         case (cur_r.op)
            FCD_OP_BYP_ON:  bypass <= 1'b1;
            FCD_OP_BYP_OFF: bypass <= 1'b0;
            FCD_OP_SUSPEND: suspended <= 1'b1;
            FCD_OP_RESUME:  suspended <= 1'b0;
            default: ;
         endcase
      end
   end
endmodule : fcd_host

// >>> fcd_pkg.sv
// Package for the flash command sequencer that drives a word-wide NOR flash
package fcd_pkg;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 22'h000555;
   localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 22'h0002aa;
   localparam logic [ADDR_W-1:0] CFI_ADDR     = 22'h000055;
   localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00aa;
   localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_RESET    = 16'h00f0;
   localparam logic [DATA_W-1:0] CMD_IDENT    = 16'h0090;
   localparam logic [DATA_W-1:0] CMD_PROG     = 16'h00a0;
   localparam logic [DATA_W-1:0] CMD_BUF_LOAD = 16'h0025;
   localparam logic [DATA_W-1:0] CMD_BUF_GO   = 16'h0029;
   localparam logic [DATA_W-1:0] CMD_BYPASS   = 16'h0020;
   localparam logic [DATA_W-1:0] CMD_BYP_EXIT = 16'h0000;
   localparam logic [DATA_W-1:0] CMD_ERASE_SU = 16'h0080;
   localparam logic [DATA_W-1:0] CMD_SEC_ERS  = 16'h0030;
   localparam logic [DATA_W-1:0] CMD_SUSPEND  = 16'h00b0;
   localparam logic [DATA_W-1:0] CMD_RESUME   = 16'h0030;
   localparam logic [DATA_W-1:0] CMD_CFI      = 16'h0098;
   // Identification offsets inside a sector
   localparam logic [7:0] ID_MAKER   = 8'h00;
   localparam logic [7:0] ID_DEV1    = 8'h01;
   localparam logic [7:0] ID_PROT    = 8'h02;
   localparam logic [7:0] ID_DEV2    = 8'h0e;
   localparam logic [7:0] ID_DEV3    = 8'h0f;
   localparam int SECT_LSB   = 15;
   localparam int PAGE_LSB   = 4;
   localparam int BUF_WORDS  = 16;
   localparam int BUF_MAX_CYC = 21;
   // Bus timing in cycles of clk_sys (5 ns)
   localparam int CLK_PS     = 5000;
   localparam int T_SETUP_PS = 35000;
   localparam int T_PULSE_PS = 35000;
   localparam int T_HOLD_PS  = 20000;
   localparam int T_ACC_PS   = 90000;
   localparam int SETUP_CYC  = (T_SETUP_PS + CLK_PS - 1) / CLK_PS;
   localparam int PULSE_CYC  = (T_PULSE_PS + CLK_PS - 1) / CLK_PS;
   localparam int HOLD_CYC   = (T_HOLD_PS + CLK_PS - 1) / CLK_PS;
   localparam int ACC_CYC    = (T_ACC_PS + CLK_PS - 1) / CLK_PS;
   localparam int CNT_W      = 6;

   typedef enum logic [3:0] {
      FCD_OP_READ, FCD_OP_RESET, FCD_OP_IDENT, FCD_OP_IDREAD, FCD_OP_PROG,
      FCD_OP_BUF, FCD_OP_ABORT, FCD_OP_BYP_ON, FCD_OP_BYP_OFF,
      FCD_OP_ERASE, FCD_OP_SUSPEND, FCD_OP_RESUME, FCD_OP_CFI
   } fcd_op_e;

   typedef struct packed {
      fcd_op_e             op;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
      logic [4:0]          count;
   } fcd_req_s;

   typedef struct packed {
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   dq_out;
      logic                dq_oe;
      logic                ce_n;
      logic                we_n;
      logic                oe_n;
   } fcd_pins_s;
endpackage : fcd_pkg

// >>> fcd_properties.sv
// Port checker for the host command sequencer
`timescale 1ns/1ps
module fcd_properties (
   input wire logic                   clk_sys,
   input wire logic                   rst_n,
   input wire logic                   clk_en,
   input wire logic                   req_valid,
   input wire logic                   req_ready,
   input wire fcd_pkg::fcd_req_s      req,
   input wire logic                   wdata_req,
   input wire logic [15:0]            wdata,
   input wire logic                   rsp_valid,
   input wire logic [15:0]            rsp_data,
   input wire logic                   suspended,
   input wire logic                   bypass,
   input wire fcd_pkg::fcd_pins_s     pins,
   input wire logic [15:0]            dq_in
);
   import fcd_pkg::*;
   fcd_op_e op_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clk_sys) begin
      if (req_valid && req_ready)
         op_r <= req.op;
   end
   AST_WE_DRIVE: assert property (!pins.we_n |-> pins.dq_oe && !pins.ce_n)
      else $error("write strobe without select or data drive");
   // Bus contention if the host drives while the flash outputs
   AST_RD_FREE: assert property (!pins.oe_n |-> !pins.dq_oe && pins.we_n)
      else $error("read strobe while host drives the bus");
   AST_PULSE: assert property ($fell(pins.we_n) |-> !pins.we_n [*7] ##1 pins.we_n)
      else $error("write pulse length wrong");
   AST_STABLE: assert property (!pins.we_n |-> $stable(pins.addr) && $stable(pins.dq_out))
      else $error("address or data moved inside write pulse");
   AST_ID_UPPER: assert property (rsp_valid && op_r == FCD_OP_IDREAD |-> rsp_data[15:8] == 8'h00)
      else $error("identification read upper byte not cleared");
   AST_RD_LAT: assert property (req_valid && req_ready && req.op == FCD_OP_READ |-> ##[25:27] rsp_valid)
      else $error("read answer late");
   AST_BYP_HOLD: assert property (req_ready && !req_valid |=> bypass == $past(bypass))
      else $error("bypass flag moved while idle");
   AST_SUS_HOLD: assert property (req_ready && !req_valid |=> suspended == $past(suspended))
      else $error("suspend flag moved while idle");
   // A frozen clock enable must hold the pins and rsp_valid
   AST_FREEZE: assert property (!clk_en |=> $stable(pins) && $stable(rsp_valid))
      else $error("output moved while clock enable low");
   AST_BYP_END: assert property ($changed(bypass) |-> req_ready && !$past(req_ready))
      else $error("bypass flag changed outside a sequence end");
   cover property (!clk_en ##1 clk_en);
   cover property ($rose(bypass));
   cover property ($rose(suspended));
   cover property (wdata_req ##1 !wdata_req);
endmodule : fcd_properties
bind fcd_host fcd_properties u_props (.clk_sys, .rst_n, .clk_en, .req_valid, .req_ready, .req,
   .wdata_req, .wdata, .rsp_valid, .rsp_data, .suspended, .bypass, .pins, .dq_in);

// >>> fcd_flash_model.sv
// Behavioural flash that logs write cycles and answers array reads
`timescale 1ns/1ps
module fcd_flash_model (
   input wire logic                   clk_sys,
   input wire fcd_pkg::fcd_pins_s     pins,
   output logic [15:0]                dq_in,
   output logic                       wr_stb,
   output logic [21:0]                wr_a,
   output logic [15:0]                wr_d
);
   import fcd_pkg::*;
   logic              on_r = 1'b0;
   logic [21:0]       a_r;
   logic [15:0]       d_r;
   wire logic on = !pins.we_n && !pins.ce_n;
   always_ff @(posedge clk_sys) begin
      on_r <= on;
      if (on && !on_r)
         a_r <= pins.addr;
      if (on)
         d_r <= pins.dq_out;
      wr_stb <= on_r && !on;
      wr_a <= a_r;
      wr_d <= d_r;
   end
   // Released bus shows the inverse so a late sample cannot pass by luck
   assign dq_in = (!pins.ce_n && !pins.oe_n) ? pins.addr[15:0] ^ 16'h3c5a
                                             : ~(pins.addr[15:0] ^ 16'h3c5a);
endmodule : fcd_flash_model

// >>> fcd_host_tb_top.sv
// Self-checking bench for the host command sequencer
`timescale 1ns/1ps
module fcd_host_tb_top;
   import fcd_pkg::*;
   localparam logic [21:0] LO = 22'h0007ff;
   localparam logic [21:0] SEC = 22'h3f8000;
   localparam logic [21:0] ALL = 22'h3fffff;
   localparam logic [21:0] NONE = 22'h000000;
   logic clk_sys, rst_n, clk_en, req_valid, req_ready, wdata_req, rsp_valid;
   logic suspended, bypass, wr_stb, pend;
   fcd_req_s req;
   fcd_pins_s pins;
   logic [15:0] wdata, rsp_data, dq_in, wr_d, rq[$], wq[$];
   logic [21:0] wr_a, a;
   logic [31:0] rnd;
   logic [59:0] e, eq[$];
   logic [7:0] ofs[5];
   int err_count, num_checks;
   fcd_host dut (.clk_sys, .rst_n, .clk_en, .req_valid, .req_ready, .req, .wdata_req, .wdata,
      .rsp_valid, .rsp_data, .suspended, .bypass, .pins, .dq_in);
   fcd_flash_model u_flash (.clk_sys, .pins, .dq_in, .wr_stb, .wr_a, .wr_d);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [15:0] fv(input logic [21:0] x);
      return x[15:0] ^ 16'h3c5a;
   endfunction : fv
   task automatic chk(input logic [37:0] g, input logic [37:0] x);
      num_checks++;
      if (g !== x) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk
   task automatic wr(input logic [21:0] x, input logic [21:0] m, input logic [15:0] v);
      eq.push_back({m, x & m, v});
   endtask : wr
   task automatic unl();
      wr(UNLOCK1_ADDR, LO, UNLOCK1_DATA);
      wr(UNLOCK2_ADDR, LO, UNLOCK2_DATA);
   endtask : unl
   task automatic cmd(input logic [15:0] v);
      unl();
      wr(UNLOCK1_ADDR, LO, v);
   endtask : cmd
   task automatic wt();
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 9000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (req_ready !== 1'b1) begin
         err_count++;
         results();
      end
   endtask : wt
   task automatic op(input fcd_op_e o, input logic [21:0] x, input logic [15:0] v,
                     input logic [4:0] c);
      req = '{o, x, v, c};
      req_valid = 1'b1;
      wt();
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
      @(posedge clk_sys);
      #1;
      wt();
   endtask : op
   task automatic results();
      if (err_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Watcher takes the oldest note whenever the bus shows a result
   always @(posedge clk_sys) begin
      #1;
      if (wr_stb === 1'b1) begin
         e = eq.pop_front();
         chk({wr_a & e[59:38], wr_d}, e[37:0]);
      end
      if (rsp_valid === 1'b1)
         chk(38'(rsp_data), 38'(rq.pop_front()));
      if (pend)
         void'(wq.pop_front());
      wdata = (wq.size() > 0) ? wq[0] : 16'h0000;
      pend = (wdata_req === 1'b1);
   end
   initial begin
      #100000;
      err_count++;
      results();
   end
   initial begin
      {rst_n, req_valid, pend} = 3'h0;
      clk_en = 1'b1;
      req = '0;
      wdata = 16'h0000;
      rnd = 32'hb0ae;
      ofs = '{ID_MAKER, ID_DEV1, ID_DEV2, ID_DEV3, ID_PROT};
      repeat (20) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      chk(38'({pins.ce_n, pins.we_n, pins.oe_n, pins.dq_oe, req_ready, bypass, suspended}), 38'h74);
      rnd = lfsr(rnd);
      a = rnd[21:0];
      rq.push_back(fv(a));
      op(FCD_OP_READ, a, 16'h0000, 5'h00);
      rnd = lfsr(rnd);
      cmd(CMD_PROG);
      wr(rnd[21:0], ALL, rnd[31:16]);
      op(FCD_OP_PROG, rnd[21:0], rnd[31:16], 5'h00);
      cmd(CMD_IDENT);
      op(FCD_OP_IDENT, UNLOCK1_ADDR, 16'h0000, 5'h00);
      for (int i = 0; i < 5; i++) begin
         a = {rnd[21:15], 7'h00, ofs[i]};
         rq.push_back(fv(a) & 16'h00ff);
         op(FCD_OP_IDREAD, a, 16'h0000, 5'h00);
      end
      wr(NONE, NONE, CMD_RESET);
      op(FCD_OP_RESET, a, 16'h0000, 5'h00);
      wr(CFI_ADDR, LO, CMD_CFI);
      // Clock enable dropped mid-setup; the write must still land intact
      fork
         op(FCD_OP_CFI, CFI_ADDR, 16'h0000, 5'h00);
         begin
            repeat (3) @(posedge clk_sys);
            #1;
            clk_en = 1'b0;
            repeat (4) @(posedge clk_sys);
            #1;
            clk_en = 1'b1;
         end
      join
      // Sixteen words is the longest legal sequence of 21 cycles
      a = {rnd[21:4], 4'h0};
      unl();
      wr(a, SEC, CMD_BUF_LOAD);
      wr(a, SEC, 16'h000f);
      for (int i = 0; i < BUF_WORDS; i++) begin
         rnd = lfsr(rnd);
         wq.push_back(rnd[15:0]);
         wr(a + 22'(i), ALL, rnd[15:0]);
      end
      wr(a, SEC, CMD_BUF_GO);
      op(FCD_OP_BUF, a | 22'(rnd[3:0]), 16'h0000, 5'h0f);
      cmd(CMD_RESET);
      op(FCD_OP_ABORT, UNLOCK1_ADDR, 16'h0000, 5'h00);
      cmd(CMD_BYPASS);
      op(FCD_OP_BYP_ON, UNLOCK1_ADDR, 16'h0000, 5'h00);
      chk(38'(bypass), 38'h1);
      rnd = lfsr(rnd);
      wr(NONE, NONE, CMD_PROG);
      wr(rnd[21:0], ALL, rnd[31:16]);
      op(FCD_OP_PROG, rnd[21:0], rnd[31:16], 5'h00);
      wr(NONE, NONE, CMD_IDENT);
      wr(NONE, NONE, CMD_BYP_EXIT);
      op(FCD_OP_BYP_OFF, a, 16'h0000, 5'h00);
      chk(38'(bypass), 38'h0);
      cmd(CMD_ERASE_SU);
      unl();
      wr(a, SEC, CMD_SEC_ERS);
      op(FCD_OP_ERASE, a, 16'h0000, 5'h00);
      wr(NONE, NONE, CMD_SUSPEND);
      op(FCD_OP_SUSPEND, UNLOCK1_ADDR, 16'h0000, 5'h00);
      chk(38'(suspended), 38'h1);
      cmd(CMD_PROG);
      wr(a ^ 22'h008000, ALL, rnd[15:0]);
      op(FCD_OP_PROG, a ^ 22'h008000, rnd[15:0], 5'h00);
      wr(NONE, NONE, CMD_RESUME);
      op(FCD_OP_RESUME, UNLOCK1_ADDR, 16'h0000, 5'h00);
      chk(38'(suspended), 38'h0);
      repeat (10) @(posedge clk_sys);
      #2;
      chk(38'(eq.size() + rq.size()), 38'h0);
      results();
   end
endmodule : fcd_host_tb_top
